//--- src/rfid_framing_options.sv
// Framing option, receive-start mirror and FIFO threshold registers
//
// Notes on behaviour
// R1: Parity-disable bit skips type A parity check
// R2: Slot-grid bit picks 18.88 or 37.77 us
// R3: Direct bit stream feeds encoder, bypassing FIFO
// R4: Short-receive bit accepts four-bit replies
// R5: Framing bit zero applies broken-byte anticollision
// R6: Host sets framing bit after anticollision
// R7: Collision after 7 pulses, or 6 when set
// R8: Mirror register bit zero copies receive-start
// R9: Receive-start held during reception, done interrupts
// R10: High-water code selects 124/120/112/96 bytes
// R11: Low-water code selects 4/8/16/32 bytes
// R12: Threshold register clears to zero on reset
// R13: Reserved bits read zero, ignore writes
module rfid_framing_options
  import rfid_opts_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic rx_sof,
  input wire logic rx_active,
  input wire logic rx_parity_bad,
  input wire logic [2:0] rx_bit_count,
  input wire logic rx_byte_done,
  input wire logic [7:0] tx_first_byte,
  input wire logic tx_active,
  input wire logic [7:0] fifo_level,
  input wire logic [2:0] subcarrier_pulses,
  input wire logic tx_bit_in,
  input wire logic fifo_tx_bit,
  output logic encoder_bit,
  output logic parity_error,
  output logic short_frame_ok,
  output logic broken_byte_framing,
  output logic collision_error,
  output logic slot_tick,
  output logic irq
);
  // ==========================================================
  // Register state
  logic [7:0] options_r;
  logic [7:0] thresholds_r;
  logic rx_start_r;
  logic [3:0] irq_status_r;
  logic [3:0] irq_enable_r;
  logic [3:0] irq_status_nxt;
  logic [7:0] rdata_nxt;
  logic rx_active_d_r;
  logic high_seen_r;
  logic low_seen_r;

  // ==========================================================
  // Decoding helpers, used for both thresholds
  function automatic logic [7:0] high_level(input logic [1:0] code);
    case (code)
      2'b00: high_level = high_level_0;
      2'b01: high_level = high_level_1;
      2'b10: high_level = high_level_2;
      default: high_level = high_level_3;
    endcase
  endfunction

  function automatic logic [7:0] low_level(input logic [1:0] code);
    case (code)
      2'b00: low_level = low_level_0;
      2'b01: low_level = low_level_1;
      2'b10: low_level = low_level_2;
      default: low_level = low_level_3;
    endcase
  endfunction

  // ==========================================================
  // Bus decode
  wire wr_options = wr && addr == type_a_special_options_addr;
  wire wr_thresholds = wr && addr == fifo_irq_thresholds_addr;
  wire wr_clear = wr && addr == irq_clear_addr;
  wire wr_enable = wr && addr == irq_enable_addr;

  // ==========================================================
  // Option fields
  wire parity_off = options_r[parity_check_disable_bit];
  wire slot_grid_select = options_r[slot_grid_select_bit];
  wire direct_bitstream_transmit = options_r[direct_bitstream_transmit_bit];
  wire short_receive = options_r[short_receive_bit];
  wire normal_framing = options_r[normal_framing_bit];
  wire six_pulses = options_r[collision_pulse_bit];
  wire [1:0] high_code = thresholds_r[fifo_high_water_lsb +: 2];
  wire [1:0] fifo_low_water_msb_lsb = thresholds_r[fifo_low_water_lsb +: 2];

  // Bypass muxes the raw stream in; fifo_tx_bit is then ignored, not stopped
  assign encoder_bit = direct_bitstream_transmit ? tx_bit_in : fifo_tx_bit; // R3
  assign parity_error = rx_parity_bad && !parity_off; // R1
  assign short_frame_ok = short_receive && rx_byte_done && rx_bit_count == 3'd4; // R4
  wire sel_cmd = tx_first_byte == anticoll_sel_1 || tx_first_byte == anticoll_sel_2
    || tx_first_byte == anticoll_sel_3;
  assign broken_byte_framing = !normal_framing && sel_cmd; // R5
  wire [2:0] pulse_limit = six_pulses ? collision_pulses_six : collision_pulses_seven;
  assign collision_error = rx_active && subcarrier_pulses >= pulse_limit; // R7

  // ==========================================================
  // Events
  wire rx_done_ev = rx_active_d_r && !rx_active; // R9
  wire high_hit = rx_active && fifo_level >= high_level(high_code); // R10
  wire low_hit = tx_active && fifo_level <= low_level(fifo_low_water_msb_lsb); // R11
  wire high_ev = high_hit && !high_seen_r;
  wire low_ev = low_hit && !low_seen_r;
  wire [3:0] events = {collision_error, low_ev, high_ev, rx_done_ev};
  wire [3:0] clr_bits = wr_clear ? wdata[3:0] : 4'h0;
  // Set wins over a clear in the same cycle
  assign irq_status_nxt = (irq_status_r & ~clr_bits) | events;
  assign irq = |(irq_status_r & irq_enable_r);

  // ==========================================================
  // Read mux; reserved bits read zero
  always_comb
  begin
    case (addr)
      type_a_special_options_addr: rdata_nxt = options_r & options_mask; // R13
      rx_start_mirror_addr: rdata_nxt = {7'h00, rx_start_r}; // R8
      fifo_irq_thresholds_addr: rdata_nxt = thresholds_r & thresholds_mask;
      irq_status_addr: rdata_nxt = {4'h0, irq_status_r};
      irq_enable_addr: rdata_nxt = {4'h0, irq_enable_r};
      default: rdata_nxt = 8'h00;
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      options_r <= options_reset;
      thresholds_r <= thresholds_reset; // R12
      irq_status_r <= irq_reset;
      irq_enable_r <= irq_reset;
      rdata <= 8'h00;
      rx_start_r <= 1'b0;
      rx_active_d_r <= 1'b0;
      high_seen_r <= 1'b0;
      low_seen_r <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_options)
        options_r <= wdata & options_mask; // R13
      if (wr_thresholds)
        thresholds_r <= wdata & thresholds_mask; // R13
      if (wr_enable)
        irq_enable_r <= wdata[3:0];
      rdata <= rd ? rdata_nxt : 8'h00;
      irq_status_r <= irq_status_nxt;
      // Start set at SOF, held until reception ends
      rx_start_r <= rx_active && (rx_sof || rx_start_r); // R9
      rx_active_d_r <= rx_active;
      // One interrupt per crossing, rearmed when the level recedes
      high_seen_r <= high_hit;
      low_seen_r <= low_hit;
    end
  end

  // ==========================================================
  // Slot grid
  slot_grid_timer u_grid (
    .core_clk(core_clk),
    .nrst(nrst),
    .ce(ce),
    .long_grid(slot_grid_select), // R2
    .grid_tick(slot_tick)
  );

  // ==========================================================
  // Checks
  parity_skip_a: assert property (@(posedge core_clk) disable iff (!nrst) // R1
    parity_off |-> !parity_error) else $error("parity error while disabled");
  bypass_path_a: assert property (@(posedge core_clk) disable iff (!nrst) // R3
    direct_bitstream_transmit |-> encoder_bit == tx_bit_in) else $error("bypass not applied");
  broken_byte_a: assert property (@(posedge core_clk) disable iff (!nrst) // R5
    broken_byte_framing |-> !normal_framing && sel_cmd) else $error("bad framing select");
  collision_count_a: assert property (@(posedge core_clk) disable iff (!nrst) // R7
    rx_active && subcarrier_pulses == 3'd6 |-> collision_error == six_pulses)
    else $error("collision pulse count wrong");
  mirror_read_a: assert property (@(posedge core_clk) disable iff (!nrst) // R8
    ce && rd && addr == rx_start_mirror_addr |=> rdata == {7'h00, $past(rx_start_r)})
    else $error("mirror read mismatch");
  rx_done_irq_a: assert property (@(posedge core_clk) disable iff (!nrst) // R9
    ce && rx_done_ev |=> irq_status_r[irq_rx_done_bit]) else $error("rx done not flagged");
  high_level_a: assert property (@(posedge core_clk) disable iff (!nrst) // R10
    rx_active && high_code == 2'b11 && fifo_level == 8'd96 |-> high_hit)
    else $error("high level wrong");
  low_level_a: assert property (@(posedge core_clk) disable iff (!nrst) // R11
    tx_active && fifo_low_water_msb_lsb == 2'b00 && fifo_level == 8'd5 |-> !low_hit)
    else $error("low level wrong");
  thresh_reset_a: assert property (@(posedge core_clk) // R12
    !nrst |=> thresholds_r == 8'h00) else $error("threshold reset wrong");
  reserved_zero_a: assert property (@(posedge core_clk) disable iff (!nrst) // R13
    options_r[7:6] == 2'b00 && thresholds_r[7:4] == 4'h0) else $error("reserved bit set");
endmodule

//--- src/rfid_opts_pkg.sv
// Package of offsets, field positions, reset values and counts for the framing option registers
package rfid_opts_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] type_a_special_options_addr = 8'h10;
  localparam logic [7:0] rx_start_mirror_addr = 8'h11;
  localparam logic [7:0] fifo_irq_thresholds_addr = 8'h14;
  localparam logic [7:0] irq_status_addr = 8'h20;
  localparam logic [7:0] irq_clear_addr = 8'h21;
  localparam logic [7:0] irq_enable_addr = 8'h22;
  // ==========================================================
  // Field positions
  localparam int parity_check_disable_bit = 5;
  localparam int slot_grid_select_bit = 4;
  localparam int direct_bitstream_transmit_bit = 3;
  localparam int short_receive_bit = 2;
  localparam int normal_framing_bit = 1;
  localparam int collision_pulse_bit = 0;
  localparam int fifo_high_water_lsb = 2;
  localparam int fifo_low_water_lsb = 0;
  // Interrupt bit positions
  localparam int irq_rx_done_bit = 0;
  localparam int irq_fifo_high_bit = 1;
  localparam int irq_fifo_low_bit = 2;
  localparam int irq_collision_bit = 3;
  // ==========================================================
  // Reset values and masks
  localparam logic [7:0] options_reset = 8'h00;
  localparam logic [7:0] thresholds_reset = 8'h00;
  localparam logic [7:0] options_mask = 8'h3F;
  localparam logic [7:0] thresholds_mask = 8'h0F;
  localparam logic [3:0] irq_reset = 4'h0;
  // ==========================================================
  // Thresholds, pulse counts and slot grid
  localparam logic [7:0] high_level_0 = 8'd124;
  localparam logic [7:0] high_level_1 = 8'd120;
  localparam logic [7:0] high_level_2 = 8'd112;
  localparam logic [7:0] high_level_3 = 8'd96;
  localparam logic [7:0] low_level_0 = 8'd4;
  localparam logic [7:0] low_level_1 = 8'd8;
  localparam logic [7:0] low_level_2 = 8'd16;
  localparam logic [7:0] low_level_3 = 8'd32;
  localparam logic [2:0] collision_pulses_seven = 3'd7;
  localparam logic [2:0] collision_pulses_six = 3'd6;
  localparam real clk_period_ns = 20.0;
  localparam real slot_short_ns = 18880.0;
  localparam real slot_long_ns = 37770.0;
  localparam logic [11:0] slot_short_cycles = 12'($rtoi(slot_short_ns / clk_period_ns));
  localparam logic [11:0] slot_long_cycles = 12'($rtoi(slot_long_ns / clk_period_ns));
  localparam logic [7:0] anticoll_sel_1 = 8'h93;
  localparam logic [7:0] anticoll_sel_2 = 8'h95;
  localparam logic [7:0] anticoll_sel_3 = 8'h97;
endpackage

//--- src/slot_grid_timer.sv
// Next-slot time grid tick generator
module slot_grid_timer
  import rfid_opts_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic long_grid,
  output logic grid_tick
);
  logic [11:0] count_r;
  logic [11:0] count_nxt;
  wire [11:0] period = long_grid ? slot_long_cycles : slot_short_cycles;
  wire at_end = (count_r >= period - 12'd1);
  assign count_nxt = at_end ? 12'h000 : count_r + 12'd1;
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      count_r <= 12'h000;
      grid_tick <= 1'b0;
    end
    else if (ce)
    begin
      count_r <= count_nxt;
      grid_tick <= at_end;
    end
  end
  tick_period_a: assert property (@(posedge core_clk) disable iff (!nrst)
    ce && at_end |=> count_r == 12'h000 && grid_tick) else $error("grid wrap without tick");
endmodule

//--- sim/host_bus_model.sv
// Host side of the register bus that issues one-cycle strobes
module host_bus_model
(
  input wire logic core_clk,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Idle bus
  initial
  begin
    {addr, wdata, wr, rd} = 18'h00000;
  end
  // ==========================================================
  // Accesses; a released bus shows inverted values, never the last ones
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge core_clk);
    {addr, wdata, wr} <= {~a, ~d, 1'b0};
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    {addr, rd} <= {a, 1'b1};
    @(posedge core_clk);
    {addr, rd} <= {~a, 1'b0};
    #1;
    d = rdata;
  endtask
endmodule

//--- sim/testbench.sv
// Self-checking bench for the framing option register block
module testbench
  import rfid_opts_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, nrst, ce, wr, rd, rx_sof, rx_active, rx_parity_bad, rx_byte_done, tx_active;
  logic tx_bit_in, fifo_tx_bit, encoder_bit, parity_error, short_frame_ok, irq;
  logic broken_byte_framing, collision_error, slot_tick;
  logic [7:0] addr, wdata, rdata, tx_first_byte, fifo_level, o;
  logic [2:0] rx_bit_count, subcarrier_pulses;
  int mismatches, checks, n;
  rfid_framing_options dut_u (.core_clk(core_clk), .nrst(nrst), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rx_sof(rx_sof), .rx_active(rx_active),
    .rx_parity_bad(rx_parity_bad), .rx_bit_count(rx_bit_count), .rx_byte_done(rx_byte_done),
    .tx_first_byte(tx_first_byte), .tx_active(tx_active), .fifo_level(fifo_level),
    .subcarrier_pulses(subcarrier_pulses), .tx_bit_in(tx_bit_in), .fifo_tx_bit(fifo_tx_bit),
    .encoder_bit(encoder_bit), .parity_error(parity_error), .short_frame_ok(short_frame_ok),
    .broken_byte_framing(broken_byte_framing), .collision_error(collision_error),
    .slot_tick(slot_tick), .irq(irq));
  host_bus_model host_u (.core_clk(core_clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata));
  // ==========================================================
  // Compare helpers and expectations
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_val({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host_u.read_reg(a, d);
    chk_val({8'h00, d}, {8'h00, exp});
  endtask
  task automatic gap(output int k);
    k = 0;
    do
    begin
      @(posedge core_clk);
      #1;
      k++;
    end
    while (slot_tick !== 1'b1 && k < 4000);
  endtask
  function automatic logic [7:0] hi_lvl(input int c);
    hi_lvl = 8'h80 - (8'h04 << c);
  endfunction
  // ==========================================================
  // Clock, watchdog and verdict
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial
  begin
    #1000000;
    mismatches++;
    test_done();
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    {nrst, rx_sof, rx_active, rx_parity_bad, rx_byte_done, tx_active} = 6'h00;
    {ce, tx_bit_in, fifo_tx_bit, rx_bit_count, subcarrier_pulses} = 9'h100;
    {tx_first_byte, fifo_level} = 16'h0000;
    void'($urandom(32'hdd25));
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    rd_chk(fifo_irq_thresholds_addr, 8'h00);
    host_u.write_reg(fifo_irq_thresholds_addr, 8'hFF);
    rd_chk(fifo_irq_thresholds_addr, 8'h0F);
    host_u.write_reg(rx_start_mirror_addr, 8'hFF);
    rd_chk(rx_start_mirror_addr, 8'h00);
    rd_chk(8'h3C, 8'h00);
    // Enable low must freeze the registers, so a write then is lost
    @(posedge core_clk);
    ce <= 1'b0;
    host_u.write_reg(type_a_special_options_addr, 8'h3F);
    ce <= 1'b1;
    rd_chk(type_a_special_options_addr, 8'h00);
    for (int i = 0; i < 12; i++)
    begin
      o = 8'($urandom);
      host_u.write_reg(type_a_special_options_addr, o);
      rd_chk(type_a_special_options_addr, o & 8'h3F);
      @(posedge core_clk);
      {tx_bit_in, fifo_tx_bit} <= 2'($urandom);
      {rx_parity_bad, rx_byte_done, rx_active, rx_bit_count, subcarrier_pulses} <= 9'h1E6;
      tx_first_byte <= 8'h93 + 8'(2 * (i % 3));
      #1;
      chk_bit(encoder_bit, o[3] ? tx_bit_in : fifo_tx_bit);
      chk_bit(parity_error, !o[5]);
      chk_bit(short_frame_ok, o[2]);
      chk_bit(broken_byte_framing, !o[1]);
      chk_bit(collision_error, o[0]);
      @(posedge core_clk);
      {rx_bit_count, subcarrier_pulses, tx_first_byte} <= {3'h3, 3'h7, 8'h92};
      #1;
      chk_bit(collision_error, 1'b1);
      chk_bit(short_frame_ok, 1'b0);
      chk_bit(broken_byte_framing, 1'b0);
    end
    @(posedge core_clk);
    {rx_active, subcarrier_pulses, rx_parity_bad} <= 5'h00;
    host_u.write_reg(type_a_special_options_addr, 8'h02);
    host_u.write_reg(irq_clear_addr, 8'hFF);
    @(posedge core_clk);
    rx_active <= 1'b1;
    @(posedge core_clk);
    rx_sof <= 1'b1;
    @(posedge core_clk);
    rx_sof <= 1'b0;
    rd_chk(rx_start_mirror_addr, 8'h01);
    rd_chk(irq_status_addr, 8'h00);
    @(posedge core_clk);
    rx_active <= 1'b0;
    rd_chk(rx_start_mirror_addr, 8'h00);
    rd_chk(irq_status_addr, 8'h01);
    chk_bit(irq, 1'b0);
    host_u.write_reg(irq_enable_addr, 8'h01);
    #1;
    chk_bit(irq, 1'b1);
    host_u.write_reg(irq_clear_addr, 8'h01);
    #1;
    chk_bit(irq, 1'b0);
    // Levels one short of the mark must stay quiet, so each code is pinned exactly
    for (int c = 0; c < 4; c++)
    begin
      host_u.write_reg(fifo_irq_thresholds_addr, 8'(c * 5));
      @(posedge core_clk);
      {rx_active, fifo_level} <= {1'b1, hi_lvl(c) - 8'h01};
      rd_chk(irq_status_addr, 8'h00);
      @(posedge core_clk);
      fifo_level <= hi_lvl(c);
      rd_chk(irq_status_addr, 8'h02);
      @(posedge core_clk);
      {rx_active, tx_active, fifo_level} <= {2'b01, (8'h04 << c) + 8'h01};
      host_u.write_reg(irq_clear_addr, 8'hFF);
      rd_chk(irq_status_addr, 8'h00);
      @(posedge core_clk);
      fifo_level <= 8'h04 << c;
      rd_chk(irq_status_addr, 8'h04);
      @(posedge core_clk);
      {tx_active, fifo_level} <= 9'h000;
      host_u.write_reg(irq_clear_addr, 8'hFF);
    end
    for (int g = 0; g < 2; g++)
    begin
      host_u.write_reg(type_a_special_options_addr, 8'(g << 4));
      gap(n);
      gap(n);
      chk_val(16'(n), 16'(g ? 37770 / 20 : 18880 / 20));
    end
    test_done();
  end
endmodule
